// File: src/ser_pkg.sv
package ser_pkg;

    localparam int SER_W = 8;

    // Standard event log bit positions
    localparam int SER_EVB_OPC = 0;
    localparam int SER_EVB_QUERY = 2;
    localparam int SER_EVB_DEVICE = 3;
    localparam int SER_EVB_EXEC = 4;
    localparam int SER_EVB_CMD = 5;
    localparam int SER_EVB_PWR = 7;

    // Bits of weight 2 and 64 never set
    localparam logic [7:0] SER_EVT_USED = 8'hBD;
    localparam logic [7:0] SER_EVT_ERRS = 8'h3C;
    localparam logic [7:0] SER_EVT_RST = 8'h80;

    // Status byte bit positions
    localparam int SER_STB_OUTP = 4;
    localparam int SER_STB_ESB = 5;
    localparam int SER_STB_RQS = 6;

    // Only message-available and event summary may request service
    localparam logic [7:0] SER_SRE_USED = 8'h30;
    localparam logic [7:0] SER_ZERO = 8'h00;
    localparam int SER_PSC_POS = 0;

    // Query selection, one-hot
    typedef enum logic [4:0] {
        SER_Q_ESR = 5'h01,
        SER_Q_ESE = 5'h02,
        SER_Q_SRE = 5'h04,
        SER_Q_STB = 5'h08,
        SER_Q_PSC = 5'h10
    } ser_query_t;

    // Operation-complete tracker states, one-hot
    typedef enum logic [1:0] {
        SER_OPC_IDLE = 2'h1,
        SER_OPC_WAIT = 2'h2
    } ser_opc_t;

endpackage

// File: src/ser_event_log.sv
`timescale 1ns/10ps
module ser_event_log
    import ser_pkg::*;
#(
    parameter int W = ser_pkg::SER_W
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Event conditions and clear
    input wire logic [W-1:0] i_set,
    input wire logic i_clear,
    // Log state and error queue push
    output logic [W-1:0] o_log,
    output logic o_err_push
);
    logic [W-1:0] log_r;
    logic [W-1:0] log_nxt;
    logic push_r;
    logic push_nxt;

    always_comb
    begin
        log_nxt = log_r;
        push_nxt = 1'b0;
        if (!i_rst_n)
        begin
            // Reset stands for power cycling
            log_nxt = SER_EVT_RST[W-1:0];
        end
        else
        begin
            // Set wins over a clear in the same cycle
            if (i_clear)
            begin
                log_nxt = '0;
            end
            log_nxt = log_nxt | (i_set & SER_EVT_USED[W-1:0]);
            push_nxt = |(i_set & SER_EVT_ERRS[W-1:0]);
        end
    end

    always_ff @(posedge i_clk)
    begin
        log_r <= log_nxt;
        push_r <= push_nxt;
    end

    assign o_log = log_r;
    assign o_err_push = push_r;
endmodule

// File: src/ser_status.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Clear-status empties the event log and the request bit; summary bit 4 stays.
// - Reading the event log clears it and hides summary bit 4 until the output buffer empties.
// - Writing zero to the service request mask clears it.
// - At power-up both masks clear if power-on clear is 1, else kept.
// - Service request mask selects which summary bits raise service requests.
// - Status bit 6 set drives the bus service request automatically.
// - Request bit clears only by clear-status, serial poll or reading the causing register.
// - Serial poll returns status byte and clears only the request bit.
// - Serial polls never stall ordinary command processing.
// - Status query returns poll value and clears nothing.
// - Status query runs in command order, not through poll hardware.
// - Bit 4 shows pending output, clears when output buffer empties.
// - Bit 5 is OR of enabled standard event bits.
// - Event bits 2 to 5 also push an error queue entry.
// - Event weights fixed; weights 2 and 64 always read zero.
// - Query error set by empty read, unread response, or both buffers full.
// - Power-on bit set after power cycled since last read or clear.
// - Event log clears on clear-status and when read, clear-on-read.
// - Writing zero to the event enable mask clears it.
// - Operation-complete sets event bit 0 once earlier commands finish.
// - Event bits latch and ignore changes until cleared.
// - Summary bits do not latch; clearing an event removes its summary.
// - Status bit 5 is event summary; bits 0 to 3 and 7 read zero.
module ser_status
    import ser_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Stored power-on clear setting, seen at reset
    input wire logic i_psc_nv,
    // Commands from the parser, in command order
    input wire logic i_cls,
    input wire logic i_ese_wr,
    input wire logic i_sre_wr,
    input wire logic i_psc_wr,
    input wire logic [ser_pkg::SER_W-1:0] i_wr_data,
    input wire logic i_query_valid,
    input wire ser_pkg::ser_query_t i_query_sel,
    input wire logic i_opc_cmd,
    input wire logic i_prior_done,
    // Event conditions
    input wire logic i_qe_empty_read,
    input wire logic i_qe_unread_resp,
    input wire logic i_qe_buffers_full,
    input wire logic i_dev_err,
    input wire logic i_exec_err,
    input wire logic i_cmd_err,
    // Output buffer state
    input wire logic i_output_pending_flag,
    // Bus serial poll
    input wire logic i_spoll,
    output logic o_spoll_valid,
    output logic [ser_pkg::SER_W-1:0] o_spoll_byte,
    // Query responses
    output logic o_resp_valid,
    output logic [ser_pkg::SER_W-1:0] o_resp_data,
    // Service request and status
    output logic o_srq,
    output logic [ser_pkg::SER_W-1:0] o_status_byte,
    output logic o_psc,
    output logic o_errq_push
);
    localparam int W = SER_W;

    logic [W-1:0] ese_r;
    logic [W-1:0] ese_nxt;
    logic [W-1:0] sre_r;
    logic [W-1:0] sre_nxt;
    logic psc_r;
    logic psc_nxt;
    logic rqs_r;
    logic rqs_nxt;
    logic [W-1:0] cause_r;
    logic [W-1:0] cause_nxt;
    logic req_prev_r;
    logic req_prev_nxt;
    logic outp_hide_r;
    logic outp_hide_nxt;
    ser_opc_t opc_r;
    ser_opc_t opc_nxt;
    logic opc_set;
    logic [W-1:0] spoll_byte_r;
    logic [W-1:0] spoll_byte_nxt;
    logic spoll_valid_r;
    logic spoll_valid_nxt;
    logic [W-1:0] resp_r;
    logic [W-1:0] resp_nxt;
    logic resp_valid_r;
    logic resp_valid_nxt;

    logic [W-1:0] evt_set;
    logic [W-1:0] evt_log;
    logic esr_read;
    logic outp_bit;
    logic esb_bit;
    logic [W-1:0] summary;
    logic [W-1:0] req_bits;
    logic req_now;
    logic [W-1:0] stb;

    function automatic logic [W-1:0] ser_bit(input int pos, input logic val);
        logic [W-1:0] b;
        b = '0;
        b[pos] = val;
        return b;
    endfunction

    assign esr_read = i_query_valid && (i_query_sel == SER_Q_ESR);

    // Condition capture
    always_comb
    begin
        evt_set = '0;
        evt_set[SER_EVB_OPC] = opc_set;
        evt_set[SER_EVB_QUERY] = i_qe_empty_read | i_qe_unread_resp | i_qe_buffers_full;
        evt_set[SER_EVB_DEVICE] = i_dev_err;
        evt_set[SER_EVB_EXEC] = i_exec_err;
        evt_set[SER_EVB_CMD] = i_cmd_err;
    end

    ser_event_log #(
        .W(W)
    ) ser_event_log_inst (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(evt_set),
        .i_clear(i_cls | esr_read),
        .o_log(evt_log),
        .o_err_push(o_errq_push)
    );

    // Live summary, no latching
    always_comb
    begin
        outp_bit = i_output_pending_flag & ~outp_hide_r;
        esb_bit = |(evt_log & ese_r);
        summary = ser_bit(SER_STB_OUTP, outp_bit) | ser_bit(SER_STB_ESB, esb_bit);
        req_bits = summary & sre_r;
        req_now = |req_bits;
        stb = summary | ser_bit(SER_STB_RQS, rqs_r);
    end

    // Masks and power-on clear setting
    always_comb
    begin
        ese_nxt = ese_r;
        sre_nxt = sre_r;
        psc_nxt = psc_r;
        if (!i_rst_n)
        begin
            psc_nxt = i_psc_nv;
            if (i_psc_nv)
            begin
                ese_nxt = SER_ZERO;
                sre_nxt = SER_ZERO;
            end
        end
        else
        begin
            if (i_ese_wr)
            begin
                ese_nxt = i_wr_data & SER_EVT_USED;
            end
            if (i_sre_wr)
            begin
                sre_nxt = i_wr_data & SER_SRE_USED;
            end
            if (i_psc_wr)
            begin
                psc_nxt = i_wr_data[SER_PSC_POS];
            end
        end
    end

    // Operation-complete tracker
    always_comb
    begin
        opc_nxt = opc_r;
        opc_set = 1'b0;
        if (!i_rst_n)
        begin
            opc_nxt = SER_OPC_IDLE;
        end
        else
        begin
            case (opc_r)
                SER_OPC_IDLE:
                begin
                    if (i_opc_cmd)
                    begin
                        opc_nxt = SER_OPC_WAIT;
                    end
                end
                SER_OPC_WAIT:
                begin
                    if (i_prior_done)
                    begin
                        opc_set = 1'b1;
                        opc_nxt = SER_OPC_IDLE;
                    end
                end
                default:
                begin
                    opc_nxt = SER_OPC_IDLE;
                end
            endcase
        end
    end

    // Request service and its cause
    always_comb
    begin
        rqs_nxt = rqs_r;
        cause_nxt = cause_r;
        req_prev_nxt = req_now;
        outp_hide_nxt = outp_hide_r;
        if (!i_rst_n)
        begin
            rqs_nxt = 1'b0;
            cause_nxt = SER_ZERO;
            req_prev_nxt = 1'b0;
            outp_hide_nxt = 1'b0;
        end
        else
        begin
            if (i_cls)
            begin
                rqs_nxt = 1'b0;
                cause_nxt = SER_ZERO;
            end
            if (i_spoll)
            begin
                rqs_nxt = 1'b0;
                cause_nxt = SER_ZERO;
            end
            if (esr_read && cause_r[SER_STB_ESB])
            begin
                rqs_nxt = 1'b0;
                cause_nxt = SER_ZERO;
            end
            // Hidden until the buffer drains, so a refill shows again
            if (esr_read)
            begin
                outp_hide_nxt = 1'b1;
            end
            else if (!i_output_pending_flag)
            begin
                outp_hide_nxt = 1'b0;
            end
            // New request wins over any clear in the same cycle
            if (req_now && !req_prev_r)
            begin
                rqs_nxt = 1'b1;
                cause_nxt = req_bits;
            end
        end
    end

    // Serial poll, served beside the command path
    always_comb
    begin
        spoll_valid_nxt = 1'b0;
        spoll_byte_nxt = spoll_byte_r;
        if (!i_rst_n)
        begin
            spoll_byte_nxt = SER_ZERO;
        end
        else if (i_spoll)
        begin
            spoll_valid_nxt = 1'b1;
            spoll_byte_nxt = stb;
        end
    end

    // Query responses, in command order
    always_comb
    begin
        resp_valid_nxt = 1'b0;
        resp_nxt = resp_r;
        if (!i_rst_n)
        begin
            resp_nxt = SER_ZERO;
        end
        else if (i_query_valid)
        begin
            resp_valid_nxt = 1'b1;
            case (i_query_sel)
                SER_Q_ESR: resp_nxt = evt_log;
                SER_Q_ESE: resp_nxt = ese_r;
                SER_Q_SRE: resp_nxt = sre_r;
                SER_Q_STB: resp_nxt = stb;
                SER_Q_PSC: resp_nxt = ser_bit(SER_PSC_POS, psc_r);
                default: resp_nxt = SER_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        ese_r <= ese_nxt;
        sre_r <= sre_nxt;
        psc_r <= psc_nxt;
        opc_r <= opc_nxt;
        rqs_r <= rqs_nxt;
        cause_r <= cause_nxt;
        req_prev_r <= req_prev_nxt;
        outp_hide_r <= outp_hide_nxt;
        spoll_valid_r <= spoll_valid_nxt;
        spoll_byte_r <= spoll_byte_nxt;
        resp_valid_r <= resp_valid_nxt;
        resp_r <= resp_nxt;
    end

    assign o_srq = rqs_r;
    assign o_status_byte = stb;
    assign o_spoll_valid = spoll_valid_r;
    assign o_spoll_byte = spoll_byte_r;
    assign o_resp_valid = resp_valid_r;
    assign o_resp_data = resp_r;
    assign o_psc = psc_r;
endmodule

// File: verification/ser_status_props.sv
`timescale 1ns/10ps
module ser_status_props
    import ser_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Watched inputs
    input wire logic i_cls,
    input wire logic i_sre_wr,
    input wire logic i_query_valid,
    input wire ser_pkg::ser_query_t i_query_sel,
    input wire logic i_qe_empty_read,
    input wire logic i_qe_unread_resp,
    input wire logic i_qe_buffers_full,
    input wire logic i_dev_err,
    input wire logic i_exec_err,
    input wire logic i_cmd_err,
    input wire logic i_spoll,
    // Watched outputs
    input wire logic o_spoll_valid,
    input wire logic [ser_pkg::SER_W-1:0] o_spoll_byte,
    input wire logic o_resp_valid,
    input wire logic [ser_pkg::SER_W-1:0] o_resp_data,
    input wire logic o_srq,
    input wire logic [ser_pkg::SER_W-1:0] o_status_byte,
    input wire logic o_errq_push
);
    logic any_err;
    assign any_err = i_qe_empty_read | i_qe_unread_resp | i_qe_buffers_full | i_dev_err
        | i_exec_err | i_cmd_err;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_poll_answer: assert property (i_spoll |=> o_spoll_valid
        && o_spoll_byte == $past(o_status_byte)) else $error("poll answer wrong");
    chk_status_zero: assert property ((o_status_byte & 8'h8F) == 8'h00)
        else $error("unused status bits set");
    chk_srq_bit: assert property (o_status_byte[6] == o_srq)
        else $error("status bit 6 differs from srq");
    // Stable status and no mask write mean no new request can win over the clear
    chk_poll_clears: assert property (i_spoll && o_srq && $stable(o_status_byte)
        && !$past(i_sre_wr) |=> !o_srq) else $error("poll left srq set");
    chk_esr_unused: assert property (i_query_valid && i_query_sel == SER_Q_ESR
        |=> (o_resp_data & 8'h42) == 8'h00) else $error("event log unused bits set");
    chk_err_push: assert property (o_errq_push == $past(any_err))
        else $error("error queue push wrong");
    chk_cls_srq: assert property (i_cls && $stable(o_status_byte) && !$past(i_sre_wr)
        |=> !o_srq) else $error("clear status left srq set");
    chk_stb_keeps: assert property (o_srq && i_query_valid && i_query_sel == SER_Q_STB
        && !i_spoll && !i_cls |=> o_srq) else $error("status query cleared srq");
    chk_stb_value: assert property (i_query_valid && i_query_sel == SER_Q_STB
        |=> o_resp_valid && o_resp_data == $past(o_status_byte)) else $error("status query");
    cov_poll_srq: cover property (i_spoll && o_srq);
    cov_err: cover property (o_errq_push);
    cov_stb: cover property (i_query_valid && i_query_sel == SER_Q_STB && o_srq);
endmodule

// File: verification/ser_ctrl_model.sv
`timescale 1ns/10ps
module ser_ctrl_model
(
    // Clock and controls
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [3:0] i_dly,
    // Bus request line and poll
    input wire logic i_srq,
    output logic o_poll
);
    logic [3:0] cnt_r;
    initial
    begin
        cnt_r = 4'h0;
        o_poll = 1'b0;
    end
    // Polls once after srq has stood i_dly+1 cycles
    always @(posedge i_clk)
    begin
        o_poll <= 1'b0;
        if (o_poll || !i_en || !i_srq)
            cnt_r <= 4'h0;
        else if (cnt_r == i_dly)
            o_poll <= 1'b1;
        else
            cnt_r <= cnt_r + 4'h1;
    end
endmodule

// File: verification/ser_status_test.sv
`timescale 1ns/10ps
module ser_status_test;
    import ser_pkg::*;
    logic i_clk, i_rst_n, i_psc_nv, i_prior_done, i_output_pending_flag, i_query_valid;
    logic en, ctl_poll, o_spoll_valid, o_resp_valid, o_srq, o_psc, o_errq_push;
    logic [11:0] c;
    logic [7:0] i_wr_data, o_spoll_byte, o_resp_data, o_status_byte;
    logic [7:0] evx [0:4] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h10};
    logic [3:0] dly;
    ser_query_t i_query_sel;
    int n_errors, compares, k, w;
    ser_status ser_status_inst (.i_clk, .i_rst_n, .i_psc_nv, .i_cls(c[1]), .i_ese_wr(c[2]),
        .i_sre_wr(c[3]), .i_psc_wr(c[4]), .i_wr_data, .i_query_valid, .i_query_sel,
        .i_opc_cmd(c[5]), .i_prior_done, .i_qe_empty_read(c[6]), .i_qe_unread_resp(c[7]),
        .i_qe_buffers_full(c[8]), .i_dev_err(c[9]), .i_exec_err(c[10]), .i_cmd_err(c[11]),
        .i_output_pending_flag, .i_spoll(c[0] | ctl_poll), .o_spoll_valid, .o_spoll_byte,
        .o_resp_valid, .o_resp_data, .o_srq, .o_status_byte, .o_psc, .o_errq_push);
    ser_ctrl_model ser_ctrl_model_inst (.i_clk, .i_en(en), .i_dly(dly), .i_srq(o_srq),
        .o_poll(ctl_poll));
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bits: 0 poll, 1 cls, 2 ese, 3 sre, 4 psc, 5 opc, 6..11 events
    task go(input logic [11:0] v, input logic [7:0] d);
        @(posedge i_clk);
        c <= v;
        i_wr_data <= d;
        @(posedge i_clk);
        c <= 12'h000;
        #1;
    endtask
    task q(input ser_query_t s, input logic [7:0] exp);
        @(posedge i_clk);
        i_query_valid <= 1'b1;
        i_query_sel <= s;
        @(posedge i_clk);
        i_query_valid <= 1'b0;
        #1;
        chk("resp_valid", {7'h00, o_resp_valid}, 8'h01);
        chk("resp_data", o_resp_data, exp);
    endtask
    task st(input logic [7:0] exp);
        repeat (2) @(posedge i_clk);
        #1;
        chk("status_byte", o_status_byte, exp);
    endtask
    task pend(input logic v);
        @(posedge i_clk);
        i_output_pending_flag <= v;
    endtask
    task rst(input logic p);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        i_psc_nv <= p;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        i_rst_n = 1'b0;
        i_psc_nv = 1'b1;
        i_prior_done = 1'b0;
        i_output_pending_flag = 1'b0;
        i_query_valid = 1'b0;
        i_query_sel = SER_Q_ESR;
        i_wr_data = 8'h00;
        c = 12'h000;
        en = 1'b0;
        dly = 4'h0;
        n_errors = 0;
        compares = 0;
        rst(1'b1);
        q(SER_Q_ESR, 8'h80);
        q(SER_Q_ESR, 8'h00);
        q(SER_Q_ESE, 8'h00);
        q(SER_Q_SRE, 8'h00);
        q(SER_Q_PSC, 8'h01);
        $display("test power_up done");
        go(12'h002, 8'h00);
        go(12'h004, 8'hFF);
        go(12'h008, 8'hFF);
        q(SER_Q_ESE, 8'hBD);
        q(SER_Q_SRE, 8'h30);
        go(12'h020, 8'h00);
        q(SER_Q_ESR, 8'h00);
        @(posedge i_clk);
        i_prior_done <= 1'b1;
        repeat (2) @(posedge i_clk);
        st(8'h60);
        q(SER_Q_ESR, 8'h01);
        st(8'h00);
        $display("test setup_opc done");
        for (k = 0; k < 5; k++)
        begin
            go(12'h040 << k, 8'h00);
            chk("err_push", {7'h00, o_errq_push}, 8'h01);
            q(SER_Q_ESR, evx[k]);
        end
        go(12'h800, 8'h00);
        st(8'h60);
        q(SER_Q_STB, 8'h60);
        st(8'h60);
        go(12'h001, 8'h00);
        chk("spoll_byte", o_spoll_byte, 8'h60);
        st(8'h20);
        go(12'h002, 8'h00);
        st(8'h00);
        q(SER_Q_ESR, 8'h00);
        $display("test events_poll done");
        pend(1'b1);
        st(8'h50);
        q(SER_Q_ESR, 8'h00);
        st(8'h40);
        pend(1'b0);
        go(12'h001, 8'h00);
        pend(1'b1);
        st(8'h50);
        pend(1'b0);
        go(12'h001, 8'h00);
        st(8'h00);
        $display("test output_pending done");
        go(12'h008, 8'h00);
        q(SER_Q_SRE, 8'h00);
        go(12'h004, 8'h00);
        q(SER_Q_ESE, 8'h00);
        go(12'h800, 8'h00);
        st(8'h00);
        q(SER_Q_ESR, 8'h20);
        $display("test masks_zero done");
        go(12'h004, 8'hFF);
        go(12'h008, 8'h20);
        for (k = 0; k < 2; k++)
        begin
            @(posedge i_clk);
            en <= 1'b1;
            dly <= 4'(k * 5);
            go(12'h200, 8'h00);
            for (w = 0; w < 20 && o_spoll_valid !== 1'b1; w++)
            begin
                @(posedge i_clk);
                #1;
            end
            chk("poll_seen", {7'h00, o_spoll_valid}, 8'h01);
            chk("ctl_poll_byte", o_spoll_byte, 8'h60);
            q(SER_Q_ESR, 8'h08);
        end
        @(posedge i_clk);
        en <= 1'b0;
        $display("test controller done");
        go(12'h004, 8'h01);
        go(12'h010, 8'h00);
        chk("psc", {7'h00, o_psc}, 8'h00);
        rst(1'b0);
        q(SER_Q_ESE, 8'h01);
        q(SER_Q_SRE, 8'h20);
        q(SER_Q_ESR, 8'h80);
        $display("test keep_masks done");
        close_out;
    end
endmodule
bind ser_status ser_status_props ser_status_props_inst (.i_clk, .i_rst_n, .i_cls, .i_sre_wr,
    .i_query_valid, .i_query_sel, .i_qe_empty_read, .i_qe_unread_resp, .i_qe_buffers_full,
    .i_dev_err, .i_exec_err, .i_cmd_err, .i_spoll, .o_spoll_valid, .o_spoll_byte,
    .o_resp_valid, .o_resp_data, .o_srq, .o_status_byte, .o_errq_push);
